// ===== design/pfc_bus_cycle.sv
// One read or write cycle on the flash pins, with pin timing.
// Assumes the flash data pins are asynchronous; they are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module pfc_bus_cycle (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [17:0]      addr_o,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [7:0]       dq_o,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_i
);

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    B_IDLE   = 3'b000,
    B_SETUP  = 3'b001,
    B_STROBE = 3'b010,
    B_HOLD   = 3'b011,
    B_GAP    = 3'b100
  } pfc_bst_t;

  typedef struct packed {
    pfc_bst_t    st;
    logic [7:0]  cnt;
    logic        rd;
    logic [17:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        done;
    logic        ce_on;
    logic        oe_on;
    logic        we_on;
    logic        dq_oe;
    logic [7:0]  s1;
    logic [7:0]  s2;
  } pfc_bus_q_t;

  pfc_bus_q_t q_ff, nxt_q;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.done = 1'b0;
    nxt_q.s1   = dq_i;
    nxt_q.s2   = q_ff.s1;
    unique case (q_ff.st)
      B_IDLE: begin
        if (start) begin
          nxt_q.rd    = is_read;
          nxt_q.addr  = addr;
          nxt_q.wdata = wdata;
          nxt_q.ce_on = 1'b1;
          nxt_q.dq_oe = !is_read;
          nxt_q.st    = B_SETUP;
        end
      end
      B_SETUP: begin
        nxt_q.oe_on = q_ff.rd;
        nxt_q.we_on = !q_ff.rd;
        nxt_q.cnt   = q_ff.rd ? 8'(pfc_pkg::ACC_CYC + pfc_pkg::SYNC_STAGES - 1)
                              : 8'(pfc_pkg::WP_CYC - 1);
        nxt_q.st    = B_STROBE;
      end
      B_STROBE: begin
        if (q_ff.cnt == 8'h00) begin
          // Sample late enough to cover access time plus the synchroniser
          if (q_ff.rd) begin
            nxt_q.rdata = q_ff.s2;
          end
          nxt_q.oe_on = 1'b0;
          nxt_q.we_on = 1'b0;
          nxt_q.st    = B_HOLD;
        end else begin
          nxt_q.cnt = q_ff.cnt - 8'h01;
        end
      end
      B_HOLD: begin
        nxt_q.ce_on = 1'b0;
        nxt_q.dq_oe = 1'b0;
        nxt_q.cnt   = 8'(pfc_pkg::WPH_CYC - 1);
        nxt_q.st    = B_GAP;
      end
      B_GAP: begin
        if (q_ff.cnt == 8'h00) begin
          nxt_q.done = 1'b1;
          nxt_q.st   = B_IDLE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 8'h01;
        end
      end
      default: nxt_q.st = B_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign done   = q_ff.done;
  assign rdata  = q_ff.rdata;
  assign addr_o = q_ff.addr;
  assign ce_n   = !q_ff.ce_on;
  assign oe_n   = !q_ff.oe_on;
  assign we_n   = !q_ff.we_on;
  assign dq_o   = q_ff.wdata;
  assign dq_oe  = q_ff.dq_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  strobe_gate_high_a : assert property (!we_n |-> (oe_n && !ce_n && dq_oe))
    else $error("write strobe without chip select, gate high or data");
  strobe_width_a : assert property ($fell(we_n) |-> (!we_n)[*5] ##1 we_n)
    else $error("write strobe width wrong");
  data_at_rise_a : assert property ($rose(we_n) |-> (dq_oe && $stable(dq_o) && !ce_n))
    else $error("data not held at strobe rise");

endmodule : pfc_bus_cycle
`default_nettype wire

// ===== design/pfc_flash_host.sv
// Host controller driving a byte-wide parallel flash through its pins.
// Assumes request and reset inputs come from logic on CORE_CLK.
`timescale 1ns/1ns
`default_nettype none
module pfc_flash_host #(
  parameter int BP_TIMEOUT_CYC = pfc_pkg::BP_CYC,
  parameter int EC_TIMEOUT_CYC = pfc_pkg::EC_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic [2:0]  CMD_OP,
  input  wire logic [17:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_DATA,
  input  wire logic        CMD_OVERRIDE,
  input  wire logic        RESET_REQ,
  output logic             RSP_VALID,
  output logic [7:0]       RSP_DATA,
  output logic             RSP_TIMEOUT,
  output logic [17:0]      FLASH_ADDR,
  output logic             FLASH_CE_N,
  output logic             FLASH_OE_N,
  output logic             FLASH_WE_N,
  output logic             FLASH_RESET_N,
  output logic             FLASH_HV_EN,
  output logic [7:0]       FLASH_DQ_O,
  output logic             FLASH_DQ_OE,
  input  wire logic [7:0]  FLASH_DQ_I
);

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_STEP  = 3'b001,
    M_WAIT  = 3'b010,
    M_POLL  = 3'b011,
    M_PWAIT = 3'b100,
    M_RST   = 3'b101,
    M_RREC  = 3'b110
  } pfc_mst_t;

  typedef struct packed {
    pfc_mst_t        st;
    pfc_pkg::pfc_op_t op;
    logic [17:0]     addr;
    logic [7:0]      wdata;
    logic [2:0]      step;
    logic            first;
    logic            last6;
    logic [31:0]     tmo;
    logic            retry;
    logic            hv;
    logic            rst_on;
    logic            rsp_valid;
    logic [7:0]      rsp_data;
    logic            rsp_tmo;
  } pfc_main_q_t;

  pfc_main_q_t q_ff, nxt_q;

  logic        bus_start;
  logic        bus_rd;
  logic        bus_done;
  logic        bus_nrst;
  logic [17:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic [2:0]  last_step;
  logic [31:0] limit;
  logic        poll_done;

  // ==========================================================
  // Sequence decode
  assign last_step = (q_ff.op == pfc_pkg::PFC_OP_PROG) ? pfc_pkg::LAST_PROG
                                                       : pfc_pkg::LAST_ERASE;
  assign limit     = (q_ff.op == pfc_pkg::PFC_OP_PROG) ? 32'(BP_TIMEOUT_CYC)
                                                       : 32'(EC_TIMEOUT_CYC);
  assign bus_start = (q_ff.st == M_STEP) || (q_ff.st == M_POLL);
  assign bus_rd    = (q_ff.st == M_POLL);
  assign bus_addr  = bus_rd ? q_ff.addr
                            : pfc_pkg::pfc_seq_addr(q_ff.op, q_ff.step, q_ff.addr);
  assign bus_wdata = pfc_pkg::pfc_seq_data(q_ff.op, q_ff.step, q_ff.wdata);
  // Strobes drop at the edge that takes the request
  assign bus_nrst  = NRST && !RESET_REQ && !q_ff.rst_on;

  assign poll_done = !q_ff.first
                     && (bus_rdata[pfc_pkg::TOGGLE_BIT] == q_ff.last6)
                     && ((q_ff.op != pfc_pkg::PFC_OP_PROG)
                         || (bus_rdata[pfc_pkg::POLL_BIT] == q_ff.wdata[pfc_pkg::POLL_BIT]));

  // ==========================================================
  // Next state
  always_comb begin
    nxt_q           = q_ff;
    nxt_q.rsp_valid = 1'b0;
    if (RESET_REQ && (q_ff.st != M_RST)) begin
      nxt_q.retry  = q_ff.retry || ((q_ff.st != M_IDLE) && (q_ff.st != M_RREC));
      nxt_q.rst_on = 1'b1;
      nxt_q.st     = M_RST;
    end else begin
      unique case (q_ff.st)
        M_IDLE: begin
          if (CMD_VALID) begin
            nxt_q.op    = pfc_pkg::pfc_op_t'(CMD_OP);
            nxt_q.addr  = CMD_ADDR;
            nxt_q.wdata = CMD_DATA;
            nxt_q.hv    = CMD_OVERRIDE;
            nxt_q.step  = 3'h0;
            nxt_q.first = 1'b1;
            nxt_q.tmo   = 32'h0;
            nxt_q.st    = (CMD_OP == pfc_pkg::PFC_OP_READ) ? M_POLL : M_STEP;
          end
        end
        M_STEP: nxt_q.st = M_WAIT;
        M_WAIT: begin
          if (bus_done) begin
            if (q_ff.step == last_step) begin
              nxt_q.st  = M_POLL;
              nxt_q.tmo = 32'h0;
            end else begin
              nxt_q.step = q_ff.step + 3'h1;
              nxt_q.st   = M_STEP;
            end
          end
        end
        M_POLL: begin
          nxt_q.tmo = q_ff.tmo + 32'h1;
          nxt_q.st  = M_PWAIT;
        end
        M_PWAIT: begin
          nxt_q.tmo = q_ff.tmo + 32'h1;
          if (bus_done) begin
            nxt_q.rsp_data = bus_rdata;
            nxt_q.rsp_tmo  = 1'b0;
            if ((q_ff.op == pfc_pkg::PFC_OP_READ) || poll_done) begin
              nxt_q.rsp_valid = 1'b1;
              nxt_q.hv        = 1'b0;
              nxt_q.st        = M_IDLE;
            end else if (q_ff.tmo >= limit) begin
              // Gives up rather than hang on a dead part
              nxt_q.rsp_valid = 1'b1;
              nxt_q.rsp_tmo   = 1'b1;
              nxt_q.hv        = 1'b0;
              nxt_q.st        = M_IDLE;
            end else begin
              nxt_q.last6 = bus_rdata[pfc_pkg::TOGGLE_BIT];
              nxt_q.first = 1'b0;
              nxt_q.st    = M_POLL;
            end
          end
        end
        M_RST: begin
          if (!RESET_REQ) begin
            nxt_q.rst_on = 1'b0;
            nxt_q.tmo    = 32'h0;
            nxt_q.st     = M_RREC;
          end
        end
        M_RREC: begin
          nxt_q.tmo = q_ff.tmo + 32'h1;
          if (q_ff.tmo == 32'(pfc_pkg::RR_CYC - 1)) begin
            nxt_q.step  = 3'h0;
            nxt_q.first = 1'b1;
            nxt_q.retry = 1'b0;
            nxt_q.tmo   = 32'h0;
            if (!q_ff.retry) begin
              nxt_q.hv = 1'b0;
              nxt_q.st = M_IDLE;
            end else begin
              nxt_q.st = (q_ff.op == pfc_pkg::PFC_OP_READ) ? M_POLL : M_STEP;
            end
          end
        end
        default: nxt_q.st = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // Pin engine
  pfc_bus_cycle u_bus (
    .clk     (CORE_CLK),
    .nrst    (bus_nrst),
    .start   (bus_start),
    .is_read (bus_rd),
    .addr    (bus_addr),
    .wdata   (bus_wdata),
    .done    (bus_done),
    .rdata   (bus_rdata),
    .addr_o  (FLASH_ADDR),
    .ce_n    (FLASH_CE_N),
    .oe_n    (FLASH_OE_N),
    .we_n    (FLASH_WE_N),
    .dq_o    (FLASH_DQ_O),
    .dq_oe   (FLASH_DQ_OE),
    .dq_i    (FLASH_DQ_I)
  );

  assign CMD_READY     = (q_ff.st == M_IDLE) && !RESET_REQ;
  assign RSP_VALID     = q_ff.rsp_valid;
  assign RSP_DATA      = q_ff.rsp_data;
  assign RSP_TIMEOUT   = q_ff.rsp_tmo;
  assign FLASH_RESET_N = !q_ff.rst_on;
  // Override level never meets a low reset
  assign FLASH_HV_EN   = q_ff.hv && !q_ff.rst_on;

  // ==========================================================
  // Checks
  logic [3:0] wr_cnt_ff;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || (q_ff.st == M_IDLE) || q_ff.rst_on) begin
      wr_cnt_ff <= 4'h0;
    end else if ($fell(FLASH_WE_N)) begin
      wr_cnt_ff <= wr_cnt_ff + 4'h1;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  chip_six_writes_a : assert property ((q_ff.st == M_WAIT) && bus_done
      && (q_ff.op == pfc_pkg::PFC_OP_CHIP) && (q_ff.step == 3'h5) |-> (wr_cnt_ff == 4'h6))
    else $error("chip erase not six writes");
  prog_four_writes_a : assert property ((q_ff.st == M_WAIT) && bus_done
      && (q_ff.op == pfc_pkg::PFC_OP_PROG) && (q_ff.step == 3'h3) |-> (wr_cnt_ff == 4'h4))
    else $error("byte program not four writes");
  busy_blocks_a : assert property ($rose(CMD_READY) |->
      (RSP_VALID || ($past(q_ff.st) == M_RREC) || $past(RESET_REQ)))
    else $error("ready returned before completion");
  reset_pin_a : assert property ((RESET_REQ && (q_ff.st != M_RST)) |=>
      (!FLASH_RESET_N && !FLASH_HV_EN && FLASH_CE_N))
    else $error("reset pin not driven low");
  retry_after_reset_a : assert property ((q_ff.st == M_RST) && !RESET_REQ
      && q_ff.retry && (q_ff.op == pfc_pkg::PFC_OP_PROG) |-> ##[1:80] $fell(FLASH_WE_N))
    else $error("interrupted program not repeated");

  prog_done_c  : cover property (RSP_VALID && !RSP_TIMEOUT
      && (q_ff.op == pfc_pkg::PFC_OP_PROG));
  chip_done_c  : cover property (RSP_VALID && (q_ff.op == pfc_pkg::PFC_OP_CHIP));
  read_done_c  : cover property (RSP_VALID && (q_ff.op == pfc_pkg::PFC_OP_READ));
  retry_c      : cover property ((q_ff.st == M_RREC) && q_ff.retry);

endmodule : pfc_flash_host
`default_nettype wire

// ===== design/pfc_pkg.sv
// Constants, types and command tables for the parallel flash host controller.
// Assumes one 125 MHz core clock and an 18-bit address, 8-bit data flash part.
package pfc_pkg;

  // ==========================================================
  // Widths and timing
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WP_NS       = 40;
  localparam int T_WPH_NS      = 30;
  localparam int T_ACC_NS      = 70;
  localparam int T_RR_NS       = 500;
  localparam int T_BP_US       = 30;
  localparam int T_EC_MS       = 4000;
  localparam int SYNC_STAGES   = 2;
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RR_CYC  = (T_RR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BP_CYC  = T_BP_US * 1000 / CLK_PERIOD_NS;
  localparam int EC_CYC  = T_EC_MS * (1000000 / CLK_PERIOD_NS);

  // ==========================================================
  // Command codes
  localparam logic [17:0] UNLK_A1     = 18'h00555;
  localparam logic [17:0] UNLK_A2     = 18'h00aaa;
  localparam logic [7:0]  UNLK_D1     = 8'haa;
  localparam logic [7:0]  UNLK_D2     = 8'h55;
  localparam logic [7:0]  CMD_ESETUP  = 8'h80;
  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_SECTOR  = 8'h30;
  localparam logic [7:0]  CMD_LOCK    = 8'h40;
  localparam logic [2:0]  LAST_PROG   = 3'h3;
  localparam logic [2:0]  LAST_ERASE  = 3'h5;
  localparam int          TOGGLE_BIT  = 6;
  localparam int          POLL_BIT    = 7;

  typedef enum logic [2:0] {
    PFC_OP_READ   = 3'b000,
    PFC_OP_PROG   = 3'b001,
    PFC_OP_CHIP   = 3'b010,
    PFC_OP_SECTOR = 3'b011,
    PFC_OP_LOCK   = 3'b100
  } pfc_op_t;

  function automatic logic [17:0] pfc_seq_addr(pfc_op_t op, logic [2:0] step,
                                               logic [17:0] tgt);
    logic [17:0] a;
    a = UNLK_A1;
    case (step)
      3'h1, 3'h4: a = UNLK_A2;
      3'h3:       a = (op == PFC_OP_PROG) ? tgt : UNLK_A1;
      3'h5:       a = (op == PFC_OP_SECTOR) ? tgt : UNLK_A1;
      default:    a = UNLK_A1;
    endcase
    return a;
  endfunction : pfc_seq_addr

  function automatic logic [7:0] pfc_seq_data(pfc_op_t op, logic [2:0] step,
                                              logic [7:0] wd);
    logic [7:0] d;
    d = UNLK_D1;
    case (step)
      3'h1, 3'h4: d = UNLK_D2;
      3'h2:       d = (op == PFC_OP_PROG) ? CMD_PROG : CMD_ESETUP;
      3'h3:       d = (op == PFC_OP_PROG) ? wd : UNLK_D1;
      3'h5:       d = (op == PFC_OP_SECTOR) ? CMD_SECTOR :
                      (op == PFC_OP_CHIP) ? CMD_CHIP : CMD_LOCK;
      default:    d = UNLK_D1;
    endcase
    return d;
  endfunction : pfc_seq_data

endpackage : pfc_pkg

// ===== tb/pfc_flash_host_bench.sv
// Self-checking bench: host controller against a behavioural flash.
// Assumes short model times that fit the reduced poll limits.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pfc_flash_host_bench;
  // ==========================================================
  // Signals
  logic        CORE_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        CMD_VALID = 1'b0;
  logic [2:0]  CMD_OP = 3'h0;
  logic [17:0] CMD_ADDR = 18'h0;
  logic [7:0]  CMD_DATA = 8'h0;
  logic        CMD_OVERRIDE = 1'b0;
  logic        RESET_REQ = 1'b0;
  logic        CMD_READY, RSP_VALID, RSP_TIMEOUT, FLASH_CE_N, FLASH_OE_N;
  logic        FLASH_WE_N, FLASH_RESET_N, FLASH_HV_EN, FLASH_DQ_OE, m_oe;
  logic [17:0] FLASH_ADDR;
  logic [7:0]  RSP_DATA, FLASH_DQ_O, m_dq, dq_w, rsp;
  logic        slow = 1'b0;
  int          n_fail = 0;
  int          n_compared = 0;

  assign dq_w = FLASH_DQ_OE ? FLASH_DQ_O : m_dq;

  pfc_flash_host #(.BP_TIMEOUT_CYC(400), .EC_TIMEOUT_CYC(800)) u_pfc_flash_host (
    .CORE_CLK, .NRST, .CMD_VALID, .CMD_READY, .CMD_OP, .CMD_ADDR, .CMD_DATA,
    .CMD_OVERRIDE, .RESET_REQ, .RSP_VALID, .RSP_DATA, .RSP_TIMEOUT, .FLASH_ADDR,
    .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N, .FLASH_RESET_N, .FLASH_HV_EN,
    .FLASH_DQ_O, .FLASH_DQ_OE, .FLASH_DQ_I(dq_w));

  pfc_flash_model u_pfc_flash_model (.addr(FLASH_ADDR), .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N), .rst_n(FLASH_RESET_N), .hv(FLASH_HV_EN),
    .slow(slow), .dq_i(dq_w), .dq_o(m_dq), .dq_oe(m_oe));

  initial forever #4 CORE_CLK = ~CORE_CLK;

  always @(negedge CORE_CLK) if (NRST && !FLASH_WE_N) begin
    `CHK("oe_in_write", 1'b1, FLASH_OE_N)
  end
  always @(negedge CORE_CLK) if (FLASH_DQ_OE && m_oe) `CHK("contention", 1'b0, 1'b1)

  // ==========================================================
  // Tasks
  task automatic tick;
    @(posedge CORE_CLK);
    #1;
  endtask : tick

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic op(input logic [2:0] c, input logic [17:0] a, input logic [7:0] d,
                    input logic ov, input logic et);
    int n;
    CMD_OP = c;
    CMD_ADDR = a;
    CMD_DATA = d;
    CMD_OVERRIDE = ov;
    CMD_VALID = 1'b1;
    n = 0;
    while (CMD_READY !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    if (n >= 200) begin
      `CHK("ready_wait", 1'b1, CMD_READY)
      end_sim();
    end
    tick();
    CMD_VALID = 1'b0;
    n = 0;
    while (RSP_VALID !== 1'b1 && n < 9000) begin
      tick();
      n++;
    end
    CMD_OVERRIDE = 1'b0;
    if (n >= 9000) begin
      `CHK("rsp_wait", 1'b1, RSP_VALID)
      end_sim();
    end
    rsp = RSP_DATA;
    `CHK("timeout", et, RSP_TIMEOUT)
  endtask : op

  task automatic rd_chk(input string nm, input logic [17:0] a, input logic [7:0] e);
    op(3'h0, a, 8'h0, 1'b0, 1'b0);
    `CHK(nm, e, rsp)
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic t_idle;
    `CHK("ce_idle", 1'b1, FLASH_CE_N)
    `CHK("we_idle", 1'b1, FLASH_WE_N)
    `CHK("rst_idle", 1'b1, FLASH_RESET_N)
    `CHK("dq_idle", 1'b0, FLASH_DQ_OE)
  endtask : t_idle

  task automatic t_prog;
    op(3'h2, 18'h0, 8'h0, 1'b0, 1'b0);
    rd_chk("erased", 18'h12345, 8'hff);
    op(3'h1, 18'h12345, 8'ha5, 1'b0, 1'b0);
    rd_chk("prog", 18'h12345, 8'ha5);
    op(3'h1, 18'h12345, 8'h5a, 1'b0, 1'b0);
    rd_chk("clear_only", 18'h12345, 8'h00);
    rd_chk("seq_addr", 18'h00555, 8'hff);
  endtask : t_prog

  task automatic t_sect;
    logic [17:0] sa [6] = '{18'h04000, 18'h06000, 18'h08000, 18'h10000, 18'h20000,
                            18'h30000};
    foreach (sa[i]) op(3'h1, sa[i] + 18'h10, 8'h00, 1'b0, 1'b0);
    foreach (sa[i]) begin
      op(3'h3, sa[i], 8'h0, 1'b0, 1'b0);
      rd_chk("sect_erased", sa[i] + 18'h10, 8'hff);
      if (i < 5) rd_chk("sect_kept", sa[i + 1] + 18'h10, 8'h00);
    end
  endtask : t_sect

  // Pin reset lands while the part is still programming
  task automatic t_reset;
    fork
      op(3'h1, 18'h2a000, 8'h0f, 1'b0, 1'b0);
      begin
        repeat (90) tick();
        RESET_REQ = 1'b1;
        tick();
        tick();
        `CHK("pin_reset", 1'b0, FLASH_RESET_N)
        `CHK("ready_reset", 1'b0, CMD_READY)
        repeat (8) tick();
        RESET_REQ = 1'b0;
      end
    join
    rd_chk("retried", 18'h2a000, 8'h0f);
  endtask : t_reset

  // Slow part: poll limit runs out, writes meanwhile are lost
  task automatic t_slow;
    slow = 1'b1;
    op(3'h2, 18'h0, 8'h0, 1'b0, 1'b1);
    slow = 1'b0;
    op(3'h1, 18'h10010, 8'h00, 1'b0, 1'b1);
    repeat (2500) tick();
    rd_chk("ignored", 18'h10010, 8'hff);
    rd_chk("chip_erased", 18'h2a000, 8'hff);
  endtask : t_slow

  task automatic t_lock;
    op(3'h1, 18'h00100, 8'h3c, 1'b0, 1'b0);
    op(3'h4, 18'h0, 8'h0, 1'b0, 1'b0);
    op(3'h2, 18'h0, 8'h0, 1'b0, 1'b0);
    rd_chk("boot_kept", 18'h00100, 8'h3c);
    op(3'h1, 18'h00100, 8'h00, 1'b0, 1'b0);
    rd_chk("boot_locked", 18'h00100, 8'h3c);
    op(3'h1, 18'h00100, 8'h0c, 1'b1, 1'b0);
    rd_chk("boot_override", 18'h00100, 8'h0c);
    op(3'h3, 18'h00000, 8'h0, 1'b1, 1'b0);
    rd_chk("boot_erased", 18'h00100, 8'hff);
  endtask : t_lock

  initial begin
    repeat (16) tick();
    NRST = 1'b1;
    tick();
    t_idle();
    t_prog();
    t_sect();
    t_reset();
    t_slow();
    t_lock();
    end_sim();
  end
endmodule : pfc_flash_host_bench
`default_nettype wire

// ===== tb/pfc_flash_model.sv
// Behavioural byte-wide flash part facing the host controller pins.
// Assumes the bench resolves the shared data wire from both drivers.
`timescale 1ns/1ns
`default_nettype none
module pfc_flash_model #(
  parameter int T_BP_NS = 1200,
  parameter int T_EC_NS = 2400
) (
  input  wire logic [17:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        hv,
  input  wire logic        slow,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  output logic             dq_oe
);
  // ==========================================================
  // State
  logic [7:0]  mem [logic [17:0]];
  logic [7:0]  rv = 8'hff;
  logic [7:0]  pd;
  logic [17:0] la;
  logic [17:0] pa;
  logic [2:0]  step = 3'h0;
  logic [1:0]  bop = 2'h0;
  logic        pg = 1'b0;
  logic        wr_on = 1'b0;
  logic        tog = 1'b0;
  logic        locked = 1'b0;
  time         t_end;

  function automatic logic [7:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd

  function automatic logic prot(input logic [17:0] a);
    return locked && !hv && a < 18'h04000;
  endfunction : prot

  function automatic logic [17:0] sec(input logic [17:0] a);
    if (a < 18'h04000) return 18'h0;
    if (a < 18'h08000) return {a[17:13], 13'h0};
    return (a < 18'h10000) ? 18'h08000 : {a[17:16], 16'h0};
  endfunction : sec

  task automatic wipe(input logic [17:0] sa, input logic all);
    logic [17:0] q[$];
    foreach (mem[k]) if ((all || sec(k) == sec(sa)) && !prot(k)) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
  endtask : wipe

  // ==========================================================
  // Command decode
  // Sequence writes never touch memory
  task automatic take(input logic [17:0] a, input logic [7:0] d);
    logic ok;
    logic u5;
    logic u2;
    u5 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2aa;
    if (bop != 2'h0) return;
    case (step)
      3'h0:       ok = u5 && d == 8'haa;
      3'h1, 3'h4: ok = u2 && d == 8'h55;
      3'h2:       ok = u5 && (d == 8'ha0 || d == 8'h80);
      3'h3:       ok = pg || (u5 && d == 8'haa);
      default:    ok = d == 8'h30 || (u5 && (d == 8'h10 || d == 8'h40));
    endcase
    if (step == 3'h2) pg = d == 8'ha0;
    step = ok ? step + 3'h1 : 3'h0;
    if (!ok || !((step == 3'h4 && pg) || step == 3'h6)) return;
    step = 3'h0;
    if ((pg || d == 8'h30) && prot(a)) return;
    if (!pg && d == 8'h40) begin
      locked = 1'b1;
      return;
    end
    bop = pg ? 2'h1 : (d == 8'h10 ? 2'h2 : 2'h3);
    pa = a;
    pd = d;
    t_end = $time + (slow ? 10 : 1) * (pg ? T_BP_NS : T_EC_NS);
  endtask : take

  // Address on later fall (sixth write: on first rise), data on first rise
  always @(ce_n or we_n) begin
    if (rst_n && !ce_n && !we_n && oe_n && !wr_on) begin
      wr_on = 1'b1;
      la = addr;
    end else if (wr_on && (ce_n || we_n)) begin
      wr_on = 1'b0;
      take(step == 3'h5 ? addr : la, dq_i);
    end
  end

  // Erase sets ones, program only clears
  always #4 if (bop != 2'h0 && $time >= t_end) begin
    if (bop == 2'h1) mem[pa] = rd(pa) & pd;
    else wipe(pa, bop == 2'h2);
    bop = 2'h0;
  end

  always @(negedge rst_n) begin
    wr_on = 1'b0;
    bop = 2'h0;
    step = 3'h0;
  end

  always @(negedge oe_n) if (!ce_n) begin
    tog = ~tog;
    rv = rd(addr);
    if (bop != 2'h0) rv[6] = tog;
    if (bop == 2'h1 && addr == pa) rv[7] = ~pd[7];
  end

  // Drive only when read; released line shows inverse
  assign dq_oe = rst_n && !ce_n && !oe_n && we_n;
  assign dq_o  = dq_oe ? rv : ~rv;
endmodule : pfc_flash_model
`default_nettype wire
